/* verilog/dglp_pkg.sv */
// Constants and types for the converter gain, latency and user pattern register block
`default_nettype none
package dglp_pkg;
  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0] IDX_SECOND_DDC_GAIN_CTRL = 6'h16;
  localparam logic [5:0] IDX_LATENCY_ALIGN_CTRL = 6'h1e;
  localparam logic [5:0] IDX_WIDEBAND_GAIN_CTRL = 6'h1f;
  localparam logic [5:0] IDX_USER_PATTERN_ONE_LOW = 6'h33;
  localparam logic [5:0] IDX_USER_PATTERN_ONE_HIGH = 6'h34;
  localparam logic [5:0] IDX_USER_PATTERN_TWO_LOW = 6'h35;
  localparam logic [5:0] IDX_USER_PATTERN_TWO_HIGH = 6'h36;
  localparam logic [5:0] IDX_TEST_PATTERN_CTRL = 6'h37;
  localparam logic [5:0] IDX_BLOCK_STATUS = 6'h38;

  // ****************************************************************
  // Field positions and widths
  // ****************************************************************
  localparam int GAIN_BIT_POS = 0;
  localparam int LAT_FIELD_LSB = 4;
  localparam int LAT_FIELD_W = 3;
  localparam int PAT_SEL_W = 4;
  localparam int SAMPLE_W = 16;
  localparam int DELAY_DEPTH = 8;
  localparam int STAT_PHASE_POS = 0;
  localparam int STAT_VALID_POS = 1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_GAIN = 1'b0;
  localparam logic [LAT_FIELD_W-1:0] RST_LAT = 3'h0;
  localparam logic [7:0] RST_PATTERN_BYTE = 8'h00;
  localparam logic [PAT_SEL_W-1:0] RST_PAT_SEL = 4'h0;
  localparam logic [31:0] RST_READDATA = 32'h0000_0000;

  // ****************************************************************
  // Test pattern selector codes
  // ****************************************************************
  typedef enum logic [PAT_SEL_W-1:0] {
    PAT_NORMAL = 4'h0,
    PAT_ZEROS = 4'h1,
    PAT_ONES = 4'h2,
    PAT_SINGLE = 4'h6,
    PAT_DOUBLE = 4'h7
  } dglp_pat_mode_type;

  // Sample stream bundle
  typedef struct packed {
    logic valid;
    logic hb_path;
    logic [SAMPLE_W-1:0] data;
  } dglp_sample_type;

  // Avalon-MM request bundle
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } dglp_avm_req_type;
endpackage
`default_nettype wire

/* verilog/dglp_gain_stage.sv */
// Registered 6 dB gain stage choosing the boost by filter path
`default_nettype none
module dglp_gain_stage (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire dglp_pkg::dglp_sample_type sample_in,
  input wire logic second_converter_gain_boost,
  input wire logic wideband_gain_boost,
  output dglp_pkg::dglp_sample_type sample_out
);
  import dglp_pkg::*;

  dglp_sample_type sample_q;
  logic boost;
  logic [SAMPLE_W-1:0] doubled;

  // Saturate instead of wrapping when the doubled value overflows
  function automatic logic [SAMPLE_W-1:0] sat_double(input logic [SAMPLE_W-1:0] x);
    logic [SAMPLE_W-1:0] r;
    r = {x[SAMPLE_W-2:0], 1'b0};
    if (x[SAMPLE_W-1] != x[SAMPLE_W-2]) begin
      r = x[SAMPLE_W-1] ? {1'b1, {(SAMPLE_W-1){1'b0}}} : {1'b0, {(SAMPLE_W-1){1'b1}}};
    end
    return r;
  endfunction

  assign boost = sample_in.hb_path ? wideband_gain_boost : second_converter_gain_boost;
  assign doubled = boost ? sat_double(sample_in.data) : sample_in.data;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_q <= '0;
    end else begin
      sample_q.valid <= sample_in.valid;
      sample_q.hb_path <= sample_in.hb_path;
      sample_q.data <= doubled;
    end
  end

  assign sample_out = sample_q;
endmodule
`default_nettype wire

/* verilog/dglp_regs.sv */
// Register bank with gain, latency alignment and user test pattern datapath
//
// Our own choice: the Avalon-MM slave port.
`default_nettype none
module dglp_regs (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire dglp_pkg::dglp_avm_req_type avm_req,
  output logic [31:0] avm_readdata,
  output logic avm_waitrequest,
  input wire dglp_pkg::dglp_sample_type sample_in,
  output dglp_pkg::dglp_sample_type sample_out
);
  import dglp_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic second_converter_gain_boost_q;
  logic wideband_gain_boost_q;
  logic [LAT_FIELD_W-1:0] latency_align_select_q;
  logic [SAMPLE_W-1:0] user_pattern_one_q;
  logic [SAMPLE_W-1:0] user_pattern_two_q;
  logic [PAT_SEL_W-1:0] pat_sel_q;
  logic waitrequest_q;
  logic [31:0] readdata_q;
  logic phase_q;
  dglp_sample_type out_q;
  dglp_sample_type gained;
  dglp_sample_type dly_q [DELAY_DEPTH];
  dglp_sample_type aligned;

  logic req;
  logic done;
  logic wr_lo;
  logic [5:0] idx;

  assign req = avm_req.read | avm_req.write;
  // Request completes in the cycle waitrequest is low
  assign done = req & ~waitrequest_q;
  assign idx = avm_req.address[7:2];
  assign wr_lo = done & avm_req.write & avm_req.byteenable[0];

  // Read value for an index, unused bits zero
  function automatic logic [31:0] read_value(input logic [5:0] i);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (i)
      IDX_SECOND_DDC_GAIN_CTRL: v[GAIN_BIT_POS] = second_converter_gain_boost_q;
      IDX_LATENCY_ALIGN_CTRL: v[LAT_FIELD_LSB +: LAT_FIELD_W] = latency_align_select_q;
      IDX_WIDEBAND_GAIN_CTRL: v[GAIN_BIT_POS] = wideband_gain_boost_q;
      IDX_USER_PATTERN_ONE_LOW: v[7:0] = user_pattern_one_q[7:0];
      IDX_USER_PATTERN_ONE_HIGH: v[7:0] = user_pattern_one_q[15:8];
      IDX_USER_PATTERN_TWO_LOW: v[7:0] = user_pattern_two_q[7:0];
      IDX_USER_PATTERN_TWO_HIGH: v[7:0] = user_pattern_two_q[15:8];
      IDX_TEST_PATTERN_CTRL: v[PAT_SEL_W-1:0] = pat_sel_q;
      IDX_BLOCK_STATUS: begin
        v[STAT_PHASE_POS] = phase_q;
        v[STAT_VALID_POS] = out_q.valid;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // Avalon-MM handshake
  // ****************************************************************
  // One wait cycle per access, then waitrequest drops for one cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest_q <= 1'b1;
    end else begin
      waitrequest_q <= ~(req & waitrequest_q);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata_q <= RST_READDATA;
    end else if (avm_req.read & waitrequest_q) begin
      readdata_q <= read_value(idx);
    end
  end

  // ****************************************************************
  // Gain control registers
  // ****************************************************************
  // reset clears fields
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      second_converter_gain_boost_q <= RST_GAIN;
      wideband_gain_boost_q <= RST_GAIN;
    end else if (wr_lo) begin
      if (idx == IDX_SECOND_DDC_GAIN_CTRL) begin
        second_converter_gain_boost_q <= avm_req.writedata[GAIN_BIT_POS];
      end
      if (idx == IDX_WIDEBAND_GAIN_CTRL) begin
        wideband_gain_boost_q <= avm_req.writedata[GAIN_BIT_POS];
      end
    end
  end

  // ****************************************************************
  // Latency alignment register
  // ****************************************************************
  // field at bits 6-4
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      latency_align_select_q <= RST_LAT;
    end else if (wr_lo && idx == IDX_LATENCY_ALIGN_CTRL) begin
      latency_align_select_q <= avm_req.writedata[LAT_FIELD_LSB +: LAT_FIELD_W];
    end
  end

  // ****************************************************************
  // User pattern and selector registers
  // ****************************************************************
  // byte-wise pattern storage
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      user_pattern_one_q <= {RST_PATTERN_BYTE, RST_PATTERN_BYTE};
      user_pattern_two_q <= {RST_PATTERN_BYTE, RST_PATTERN_BYTE};
    end else if (wr_lo) begin
      if (idx == IDX_USER_PATTERN_ONE_LOW) begin
        user_pattern_one_q[7:0] <= avm_req.writedata[7:0];
      end
      if (idx == IDX_USER_PATTERN_ONE_HIGH) begin
        user_pattern_one_q[15:8] <= avm_req.writedata[7:0];
      end
      if (idx == IDX_USER_PATTERN_TWO_LOW) begin
        user_pattern_two_q[7:0] <= avm_req.writedata[7:0];
      end
      if (idx == IDX_USER_PATTERN_TWO_HIGH) begin
        user_pattern_two_q[15:8] <= avm_req.writedata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pat_sel_q <= RST_PAT_SEL;
    end else if (wr_lo && idx == IDX_TEST_PATTERN_CTRL) begin
      pat_sel_q <= avm_req.writedata[PAT_SEL_W-1:0];
    end
  end

  // ****************************************************************
  // Gain stage
  // ****************************************************************
  dglp_gain_stage u_gain (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sample_in(sample_in),
    .second_converter_gain_boost(second_converter_gain_boost_q),
    .wideband_gain_boost(wideband_gain_boost_q),
    .sample_out(gained)
  );

  // ****************************************************************
  // Latency alignment delay line
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DELAY_DEPTH; i++) begin
        dly_q[i] <= '0;
      end
    end else begin
      dly_q[0] <= gained;
      for (int i = 1; i < DELAY_DEPTH; i++) begin
        dly_q[i] <= dly_q[i-1];
      end
    end
  end

  always_comb begin
    aligned = gained;
    if (latency_align_select_q != RST_LAT) begin
      aligned = dly_q[latency_align_select_q - 3'h1];
    end
  end

  // ****************************************************************
  // Test pattern insertion
  // ****************************************************************
  // Double mode phase flips each cycle, restarts on pattern one
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= 1'b0;
    end else if (pat_sel_q == PAT_DOUBLE) begin
      phase_q <= ~phase_q;
    end else begin
      phase_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_q <= '0;
    end else begin
      out_q <= aligned;
      unique case (pat_sel_q)
        PAT_ZEROS: out_q.data <= {SAMPLE_W{1'b0}};
        PAT_ONES: out_q.data <= {SAMPLE_W{1'b1}};
        PAT_SINGLE: out_q.data <= user_pattern_one_q;
        PAT_DOUBLE: out_q.data <= phase_q ? user_pattern_two_q : user_pattern_one_q;
        default: out_q.data <= aligned.data;
      endcase
    end
  end

  assign avm_readdata = readdata_q;
  assign avm_waitrequest = waitrequest_q;
  assign sample_out = out_q;
endmodule
`default_nettype wire

/* tb/dglp_regs_properties.sv */
// Port-level assertions for the register block
`default_nettype none
module dglp_regs_properties (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire dglp_pkg::dglp_avm_req_type avm_req,
  input wire logic [31:0] avm_readdata,
  input wire logic avm_waitrequest,
  input wire dglp_pkg::dglp_sample_type sample_in,
  input wire dglp_pkg::dglp_sample_type sample_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import dglp_pkg::*;
  logic [2:0] lat_q;
  logic [8:0] vh_q;
  logic [8:0] ph_q;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // Latency field as last written
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lat_q <= 3'h0;
    end else if (avm_req.write && !avm_waitrequest && avm_req.byteenable[0]
                 && avm_req.address[7:2] == IDX_LATENCY_ALIGN_CTRL) begin
      lat_q <= avm_req.writedata[6:4];
    end
  end
  // History of input flags
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vh_q <= 9'h0;
      ph_q <= 9'h0;
    end else begin
      vh_q <= {vh_q[7:0], sample_in.valid};
      ph_q <= {ph_q[7:0], sample_in.hb_path};
    end
  end
  sequence req_wait;
    (avm_req.read || avm_req.write) && avm_waitrequest;
  endsequence
  sequence rd_done;
    !avm_waitrequest && $past(avm_req.read);
  endsequence
  wait_answer_a: assert property (req_wait |=> !avm_waitrequest)
    else $error("waitrequest not released");
  wait_single_a: assert property (!avm_waitrequest |=> avm_waitrequest)
    else $error("waitrequest low too long");
  wait_idle_a: assert property (!(avm_req.read || avm_req.write) |=> avm_waitrequest)
    else $error("waitrequest low while idle");
  reset_zero_a: assert property ($rose(rst_b) |-> avm_readdata == 32'h0 && sample_out == '0)
    else $error("outputs not zero after reset");
  rdata_hold_a: assert property (avm_waitrequest || !$past(avm_req.read) |-> $stable(avm_readdata))
    else $error("read data changed outside a read");
  lat_field_a: assert property (rd_done ##0 $past(avm_req.address[7:2]) == IDX_LATENCY_ALIGN_CTRL
    |-> avm_readdata == {25'h0, lat_q, 4'h0}) else $error("latency field readback wrong");
  gain_field_a: assert property (rd_done ##0 ($past(avm_req.address[7:2]) == IDX_SECOND_DDC_GAIN_CTRL
    || $past(avm_req.address[7:2]) == IDX_WIDEBAND_GAIN_CTRL) |-> avm_readdata[31:1] == 31'h0)
    else $error("gain register unused bits set");
  flags_delay_a: assert property (sample_out.valid == vh_q[lat_q + 4'd1]
    && sample_out.hb_path == ph_q[lat_q + 4'd1]) else $error("sample flags misaligned");
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking testbench for the register block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dglp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  dglp_avm_req_type avm_req = '0;
  logic [31:0] avm_readdata;
  logic avm_waitrequest;
  dglp_sample_type sample_in = '0;
  dglp_sample_type sample_out;
  int failures = 0;
  int comparisons = 0;
  logic [31:0] rd_q;
  logic [7:0] pb [4] = '{8'h34, 8'h12, 8'hcd, 8'hab};
  dglp_regs dglp_regs_inst (.sys_clk(sys_clk), .rst_b(rst_b), .avm_req(avm_req),
    .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
    .sample_in(sample_in), .sample_out(sample_out));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic test_done();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ****************************************************************
  // Bus and stream helpers
  // ****************************************************************
  task automatic bus(logic wr, logic [5:0] idx, logic [7:0] d);
    int n;
    avm_req <= '{read: !wr, write: wr, address: {idx, 2'b00}, byteenable: 4'hf,
      writedata: {24'h0, d}};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avm_waitrequest !== 1'b0 && n < 20);
    rd_q = avm_readdata;
    avm_req <= '0;
    @(posedge sys_clk);
    if (n >= 20) begin
      failures++;
      test_done();
    end
  endtask
  task automatic steady(logic hb, logic [15:0] d, logic [15:0] exp);
    sample_in <= {1'b1, hb, d};
    repeat (12) @(posedge sys_clk);
    check({16'h0, sample_out.data}, {16'h0, exp});
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [5:0] ri [9] = '{6'h16, 6'h1e, 6'h1f, 6'h33, 6'h34, 6'h35, 6'h36, 6'h38, 6'h20};
    foreach (ri[i]) begin
      bus(1'b0, ri[i], 8'h00);
      check(rd_q, 32'h0);
    end
    $display("t_reset done");
  endtask
  task automatic t_regs();
    logic [7:0] ls [4] = '{8'h10, 8'h20, 8'h40, 8'h50};
    int n;
    foreach (pb[i]) bus(1'b1, IDX_USER_PATTERN_ONE_LOW + 6'(i), pb[i]);
    foreach (pb[i]) begin
      bus(1'b0, IDX_USER_PATTERN_ONE_LOW + 6'(i), 8'h00);
      check(rd_q, {24'h0, pb[i]});
    end
    foreach (ls[i]) begin
      bus(1'b1, IDX_LATENCY_ALIGN_CTRL, ls[i]);
      bus(1'b0, IDX_LATENCY_ALIGN_CTRL, 8'h00);
      check(rd_q, {24'h0, ls[i]});
      sample_in <= '0;
      repeat (12) @(posedge sys_clk);
      sample_in <= {1'b1, 1'b0, 16'h0f0f};
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (sample_out.data !== 16'h0f0f && n < 20);
      check(32'(n), 32'd3 + 32'(ls[i][6:4]));
    end
    $display("t_regs done");
  endtask
  task automatic t_gain();
    bus(1'b1, IDX_SECOND_DDC_GAIN_CTRL, 8'h01);
    bus(1'b0, IDX_SECOND_DDC_GAIN_CTRL, 8'h00);
    check(rd_q, 32'h1);
    steady(1'b0, 16'h1234, 16'h2468);
    steady(1'b1, 16'h1234, 16'h1234);
    bus(1'b1, IDX_WIDEBAND_GAIN_CTRL, 8'h01);
    steady(1'b1, 16'h1234, 16'h2468);
    steady(1'b1, 16'h5000, 16'h7fff);
    steady(1'b1, 16'hb000, 16'h8000);
    bus(1'b1, IDX_SECOND_DDC_GAIN_CTRL, 8'h00);
    steady(1'b0, 16'h1234, 16'h1234);
    bus(1'b1, IDX_WIDEBAND_GAIN_CTRL, 8'h00);
    steady(1'b1, 16'h1234, 16'h1234);
    $display("t_gain done");
  endtask
  task automatic t_pat();
    logic [7:0] md [3] = '{8'h06, 8'h01, 8'h02};
    logic [15:0] ex [3] = '{16'h1234, 16'h0000, 16'hffff};
    logic [15:0] a;
    logic [15:0] b;
    foreach (md[i]) begin
      bus(1'b1, IDX_TEST_PATTERN_CTRL, md[i]);
      steady(1'b0, 16'h0777, ex[i]);
    end
    bus(1'b1, IDX_TEST_PATTERN_CTRL, 8'h07);
    repeat (12) @(posedge sys_clk);
    a = sample_out.data;
    @(posedge sys_clk);
    b = sample_out.data;
    check({a, b}, 32'habcd1234);
    bus(1'b1, IDX_TEST_PATTERN_CTRL, 8'h00);
    steady(1'b0, 16'h0777, 16'h0777);
    bus(1'b0, IDX_BLOCK_STATUS, 8'h00);
    check(rd_q, 32'h2);
    $display("t_pat done");
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_regs();
    t_gain();
    t_pat();
    test_done();
  end
endmodule
bind dglp_regs dglp_regs_properties dglp_regs_properties_inst (.sys_clk(sys_clk),
  .rst_b(rst_b), .avm_req(avm_req), .avm_readdata(avm_readdata),
  .avm_waitrequest(avm_waitrequest), .sample_in(sample_in), .sample_out(sample_out));
`default_nettype wire
